// File: ieaf_pkg.sv
// constants, field positions and carriers shared by the interrupt
// enable and request flag block and its helpers.
// assumes one 200 MHz system clock and a synchronous active-high reset.
package ieaf_pkg;

  // register offsets on the byte-wide register port
  localparam logic [7:0] ENABLE_TWO_OFFSET = 8'h00;
  localparam logic [7:0] FLAGS_ONE_OFFSET = 8'h01;
  localparam logic [7:0] ENABLE_ONE_OWN_OFFSET = 8'h02;
  localparam logic [7:0] PIN_CONFIG_OFFSET = 8'h03;

  // second enable register field positions
  localparam int DT_EN_BIT = 7;
  localparam int AD_EN_BIT = 6;
  localparam int TFH_EN_BIT = 3;
  localparam int TFL_EN_BIT = 2;
  localparam int EC_EN_BIT = 0;

  // first request register field positions
  localparam int TA_FLAG_BIT = 7;
  localparam int FIXED_ONE_BIT = 5;
  localparam int EVP_FLAG_BIT = 2;
  localparam int PIN1_FLAG_BIT = 1;
  localparam int PIN0_FLAG_BIT = 0;

  // pin configuration register field positions
  localparam int EVP_IS_INT_BIT = 6;
  localparam int PIN1_IS_INT_BIT = 5;
  localparam int PIN0_IS_INT_BIT = 4;
  localparam int EVP_EDGE_BIT = 2;
  localparam int PIN1_EDGE_BIT = 1;
  localparam int PIN0_EDGE_BIT = 0;

  // implemented-bit masks and reset values
  localparam logic [7:0] ENABLE_TWO_MASK = 8'hCD;
  localparam logic [7:0] FLAGS_ONE_MASK = 8'h87;
  localparam logic [7:0] ENABLE_ONE_OWN_MASK = 8'h87;
  localparam logic [7:0] PIN_CONFIG_MASK = 8'h77;
  localparam logic [7:0] ENABLE_TWO_RESET = 8'h00;
  localparam logic [7:0] FLAGS_ONE_RESET = 8'h00;
  localparam logic [7:0] FIXED_ONE_VALUE = 8'h20;
  localparam logic [7:0] ENABLE_ONE_OWN_RESET = 8'h00;
  localparam logic [7:0] PIN_CONFIG_RESET = 8'h00;
  localparam logic [7:0] COUNTER_ALL_ONES = 8'hFF;
  localparam logic [7:0] COUNTER_ZERO = 8'h00;

  // register port request from the cpu core
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } ieaf_bus_req_type;

  // request levels from the sources gated by the second enable register
  typedef struct packed {
    logic direct_transition;
    logic conversion_end;
    logic upper_timer_half;
    logic lower_timer_half;
    logic event_counter;
  } ieaf_src_type;

  // gated requests toward the cpu core
  typedef struct packed {
    logic direct_transition;
    logic conversion_end;
    logic upper_timer_half;
    logic lower_timer_half;
    logic event_counter;
    logic interval_timer;
    logic event_pin;
    logic ext_pin1;
    logic ext_pin0;
  } ieaf_irq_type;

endpackage

// File: ieaf_edge_detect.sv
// selected-edge detector for one external interrupt pin.
// assumes the pin is already synchronous to clk_sys.
module ieaf_edge_detect (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic pin,
  input wire logic is_interrupt,
  input wire logic rising_sel,
  output logic edge_pulse
);

  typedef struct packed {
    logic primed;
    logic prev;
    logic pulse;
  } ieaf_edge_state_type;

  ieaf_edge_state_type state;
  ieaf_edge_state_type next_state;

  // no detection on the first cycle after reset: prev is not yet real
  always_comb begin
    next_state = state;
    next_state.primed = 1'b1;
    next_state.prev = pin;
    next_state.pulse = state.primed & is_interrupt &
      (rising_sel ? (pin & ~state.prev) : (~pin & state.prev));
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign edge_pulse = state.pulse;

endmodule

// File: ieaf_wrap_detect.sv
// wrap detector for the interval timer counter, all ones to zero.
// assumes the counter value is synchronous to clk_sys.
module ieaf_wrap_detect (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [7:0] count,
  output logic wrap_pulse
);

  typedef struct packed {
    logic primed;
    logic [7:0] prev;
    logic pulse;
  } ieaf_wrap_state_type;

  ieaf_wrap_state_type state;
  ieaf_wrap_state_type next_state;

  // a load straight to zero from another value is not a wrap
  always_comb begin
    next_state = state;
    next_state.primed = 1'b1;
    next_state.prev = count;
    next_state.pulse = state.primed &
      (state.prev == ieaf_pkg::COUNTER_ALL_ONES) &
      (count == ieaf_pkg::COUNTER_ZERO);
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign wrap_pulse = state.pulse;

endmodule

// File: ieaf_interrupt_flags.sv
// interrupt enable and request flag registers of the cpu core.
// assumes a byte register port driven by the core on clk_sys, source
// request levels and pins already synchronous to clk_sys.
//
// Summary of operation
// - enable bit 7 gates the direct-transition request, reset 0
// - enable bit 6 gates the conversion-end request, reset 0
// - enable bit 3 gates the upper timer-half request, reset 0
// - enable bit 2 gates the lower timer-half request, reset 0
// - enable bit 0 gates the event counter request, reset 0
// - each defined flag sets when its source raises a request
// - interrupt acceptance never clears a flag
// - writing 0 clears a flag, writing 1 leaves it alone
// - flag bit 7 sets when the interval timer wraps to zero
// - flag bit 5 always reads 1 and ignores writes
// - flag bit 2 sets on the selected edge of the event pin
// - flag bits 1 and 0 set on selected edges of pins 1 and 0
// - per-pin edge select, 0 falling and 1 rising
//
// The strobed register port and the register addresses were decided locally.
module ieaf_interrupt_flags (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire ieaf_pkg::ieaf_bus_req_type bus_req,
  output logic [7:0] bus_rdata,
  input wire ieaf_pkg::ieaf_src_type src_req,
  input wire logic [7:0] interval_timer_count,
  input wire logic event_counter_interrupt_pin,
  input wire logic external_interrupt_pin1,
  input wire logic external_interrupt_pin0,
  output ieaf_pkg::ieaf_irq_type irq
);

  // whole block state, registered in one place
  typedef struct packed {
    logic [7:0] interrupt_enable_two;
    logic [7:0] interrupt_request_flags_one;
    logic [7:0] enable_one_own;
    logic [7:0] pin_config;
    logic [7:0] rdata;
    ieaf_pkg::ieaf_irq_type irq;
  } ieaf_state_type;

  ieaf_state_type state;
  ieaf_state_type next_state;

  logic interval_timer_wrap;
  logic event_pin_edge;
  logic ext_pin1_edge;
  logic ext_pin0_edge;
  logic [7:0] flag_set;

  // register hit for one strobe at one offset
  function automatic logic reg_hit(
    input logic strobe,
    input logic [7:0] addr,
    input logic [7:0] offset
  );
    reg_hit = strobe & (addr == offset);
  endfunction

  // masked write of a plain read/write register
  function automatic logic [7:0] masked_write(
    input logic [7:0] old_value,
    input logic [7:0] wdata,
    input logic [7:0] mask
  );
    masked_write = (old_value & ~mask) | (wdata & mask);
  endfunction

  // interval timer wrap, all ones to zero
  ieaf_wrap_detect u_timer_wrap (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .count(interval_timer_count),
    .wrap_pulse(interval_timer_wrap)
  );

  // event counter pin edge, only while configured as interrupt input
  ieaf_edge_detect u_event_pin (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .pin(event_counter_interrupt_pin),
    .is_interrupt(state.pin_config[ieaf_pkg::EVP_IS_INT_BIT]),
    .rising_sel(state.pin_config[ieaf_pkg::EVP_EDGE_BIT]),
    .edge_pulse(event_pin_edge)
  );

  // external pin 1 edge with its own edge select
  ieaf_edge_detect u_ext_pin1 (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .pin(external_interrupt_pin1),
    .is_interrupt(state.pin_config[ieaf_pkg::PIN1_IS_INT_BIT]),
    .rising_sel(state.pin_config[ieaf_pkg::PIN1_EDGE_BIT]),
    .edge_pulse(ext_pin1_edge)
  );

  // external pin 0 edge with its own edge select
  ieaf_edge_detect u_ext_pin0 (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .pin(external_interrupt_pin0),
    .is_interrupt(state.pin_config[ieaf_pkg::PIN0_IS_INT_BIT]),
    .rising_sel(state.pin_config[ieaf_pkg::PIN0_EDGE_BIT]),
    .edge_pulse(ext_pin0_edge)
  );

  // set vector lined up with the request register bit positions
  always_comb begin
    flag_set = 8'h00;
    flag_set[ieaf_pkg::TA_FLAG_BIT] = interval_timer_wrap;
    flag_set[ieaf_pkg::EVP_FLAG_BIT] = event_pin_edge;
    flag_set[ieaf_pkg::PIN1_FLAG_BIT] = ext_pin1_edge;
    flag_set[ieaf_pkg::PIN0_FLAG_BIT] = ext_pin0_edge;
  end

  // next state: register writes, flag bookkeeping, reads, gating
  always_comb begin
    next_state = state;

    // second enable register, reserved bits never stored
    if (reg_hit(bus_req.wr, bus_req.addr,
        ieaf_pkg::ENABLE_TWO_OFFSET)) begin
      next_state.interrupt_enable_two = masked_write(
        state.interrupt_enable_two, bus_req.wdata,
        ieaf_pkg::ENABLE_TWO_MASK);
    end

    // flags: a written 0 clears, a written 1 keeps; reserved ignored
    if (reg_hit(bus_req.wr, bus_req.addr,
        ieaf_pkg::FLAGS_ONE_OFFSET)) begin
      next_state.interrupt_request_flags_one =
        state.interrupt_request_flags_one &
        (bus_req.wdata | ~ieaf_pkg::FLAGS_ONE_MASK);
    end

    // set after clear so a same-cycle event is never lost
    next_state.interrupt_request_flags_one =
      next_state.interrupt_request_flags_one |
      (flag_set & ieaf_pkg::FLAGS_ONE_MASK);

    // enables for the first request register group
    if (reg_hit(bus_req.wr, bus_req.addr,
        ieaf_pkg::ENABLE_ONE_OWN_OFFSET)) begin
      next_state.enable_one_own = masked_write(state.enable_one_own,
        bus_req.wdata, ieaf_pkg::ENABLE_ONE_OWN_MASK);
    end

    // pin role and edge selection
    if (reg_hit(bus_req.wr, bus_req.addr,
        ieaf_pkg::PIN_CONFIG_OFFSET)) begin
      next_state.pin_config = masked_write(state.pin_config,
        bus_req.wdata, ieaf_pkg::PIN_CONFIG_MASK);
    end

    // read data stands one cycle after the strobe, zero otherwise
    next_state.rdata = 8'h00;
    if (bus_req.rd) begin
      unique case (bus_req.addr)
        ieaf_pkg::ENABLE_TWO_OFFSET: begin
          next_state.rdata = state.interrupt_enable_two;
        end
        ieaf_pkg::FLAGS_ONE_OFFSET: begin
          next_state.rdata = state.interrupt_request_flags_one |
            ieaf_pkg::FIXED_ONE_VALUE;
        end
        ieaf_pkg::ENABLE_ONE_OWN_OFFSET: begin
          next_state.rdata = state.enable_one_own;
        end
        ieaf_pkg::PIN_CONFIG_OFFSET: begin
          next_state.rdata = state.pin_config;
        end
        default: begin
          next_state.rdata = 8'h00; // unmapped reads as zero
        end
      endcase
    end

    // source levels gated by the second enable register
    next_state.irq.direct_transition = src_req.direct_transition &
      state.interrupt_enable_two[ieaf_pkg::DT_EN_BIT];
    next_state.irq.conversion_end = src_req.conversion_end &
      state.interrupt_enable_two[ieaf_pkg::AD_EN_BIT];
    next_state.irq.upper_timer_half = src_req.upper_timer_half &
      state.interrupt_enable_two[ieaf_pkg::TFH_EN_BIT];
    next_state.irq.lower_timer_half = src_req.lower_timer_half &
      state.interrupt_enable_two[ieaf_pkg::TFL_EN_BIT];
    next_state.irq.event_counter = src_req.event_counter &
      state.interrupt_enable_two[ieaf_pkg::EC_EN_BIT];

    // own flags gated by their enables; flags stay until cleared
    next_state.irq.interval_timer =
      state.interrupt_request_flags_one[ieaf_pkg::TA_FLAG_BIT] &
      state.enable_one_own[ieaf_pkg::TA_FLAG_BIT];
    next_state.irq.event_pin =
      state.interrupt_request_flags_one[ieaf_pkg::EVP_FLAG_BIT] &
      state.enable_one_own[ieaf_pkg::EVP_FLAG_BIT];
    next_state.irq.ext_pin1 =
      state.interrupt_request_flags_one[ieaf_pkg::PIN1_FLAG_BIT] &
      state.enable_one_own[ieaf_pkg::PIN1_FLAG_BIT];
    next_state.irq.ext_pin0 =
      state.interrupt_request_flags_one[ieaf_pkg::PIN0_FLAG_BIT] &
      state.enable_one_own[ieaf_pkg::PIN0_FLAG_BIT];
  end

  // one register stage for the whole block
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state.interrupt_enable_two <= ieaf_pkg::ENABLE_TWO_RESET;
      state.interrupt_request_flags_one <= ieaf_pkg::FLAGS_ONE_RESET;
      state.enable_one_own <= ieaf_pkg::ENABLE_ONE_OWN_RESET;
      state.pin_config <= ieaf_pkg::PIN_CONFIG_RESET;
      state.rdata <= 8'h00;
      state.irq <= '0;
    end else begin
      state <= next_state;
    end
  end

  // outputs come straight from the state register
  assign bus_rdata = state.rdata;
  assign irq = state.irq;

endmodule

// File: ieaf_checker_properties.sv
// concurrent checks on the ports of the interrupt flag block.
// assumes it is bound to ieaf_interrupt_flags and sees only its ports.
module ieaf_checker (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire ieaf_pkg::ieaf_bus_req_type bus_req,
  input wire logic [7:0] bus_rdata,
  input wire ieaf_pkg::ieaf_src_type src_req,
  input wire ieaf_pkg::ieaf_irq_type irq
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] en;

  // shadow of the enable register, rebuilt from bus writes
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      en <= 8'h00;
    end else if (bus_req.wr && bus_req.addr == 8'h00) begin
      en <= bus_req.wdata & ieaf_pkg::ENABLE_TWO_MASK;
    end
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);

  // gated level is source and enable as both stood one edge earlier
  property p_gate(logic q, logic s, logic e);
    q == ($past(s) && $past(e));
  endproperty

  a_dt_gate:
  assert property (p_gate(irq.direct_transition,
    src_req.direct_transition, en[7])) else $error("dt gate wrong");
  a_ad_gate:
  assert property (p_gate(irq.conversion_end,
    src_req.conversion_end, en[6])) else $error("ad gate wrong");
  a_tfh_gate:
  assert property (p_gate(irq.upper_timer_half,
    src_req.upper_timer_half, en[3])) else $error("tfh gate wrong");
  a_tfl_gate:
  assert property (p_gate(irq.lower_timer_half,
    src_req.lower_timer_half, en[2])) else $error("tfl gate wrong");
  a_ec_gate:
  assert property (p_gate(irq.event_counter,
    src_req.event_counter, en[0])) else $error("ec gate wrong");
  a_rdata_idle:
  assert property (!$past(bus_req.rd) |-> bus_rdata == 8'h00)
    else $error("read data outside read slot");
  a_fixed_one:
  assert property ($past(bus_req.rd && bus_req.addr == 8'h01)
    |-> bus_rdata[5]) else $error("flag bit 5 not 1");
  a_unmapped_zero:
  assert property ($past(bus_req.rd && bus_req.addr > 8'h03)
    |-> bus_rdata == 8'h00) else $error("unmapped read not 0");
  a_enable_read:
  assert property ($past(bus_req.rd && bus_req.addr == 8'h00)
    |-> bus_rdata == $past(en)) else $error("enable readback wrong");

  c_dt: cover property (irq.direct_transition);
  c_pin0: cover property (irq.ext_pin0);
  c_timer: cover property (irq.interval_timer);
endmodule

// File: ieaf_cpu_model.sv
// cpu core model driving the byte register port.
// assumes callers enter its tasks just after a rising clk_sys edge.
module ieaf_cpu_model (
  input wire logic clk_sys,
  output ieaf_pkg::ieaf_bus_req_type bus_req,
  input wire logic [7:0] bus_rdata
);
  timeunit 1ns;
  timeprecision 100ps;

  initial bus_req = '0;

  // software clears reserved bits only on writes to offsets 00 and 01; flag bit 5 passes through
  function automatic logic [7:0] keep(input logic [7:0] a);
    case (a)
      8'h00: keep = ieaf_pkg::ENABLE_TWO_MASK;
      8'h01: keep = 8'hA7;
      default: keep = 8'hFF;
    endcase
  endfunction

  // one-cycle write strobe, idle cycle after so strobes never overlap
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus_req <= '{addr: a, wdata: d & keep(a), wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys);
    bus_req <= '0;
    @(posedge clk_sys);
  endtask

  // read data are taken in the single cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys);
    bus_req <= '0;
    #1;
    d = bus_rdata;
    @(posedge clk_sys);
  endtask
endmodule

// File: tb.sv
// self-checking bench for the interrupt enable and request flag block.
// assumes the cpu model and checker files are compiled before it.
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  ieaf_pkg::ieaf_bus_req_type bus_req;
  logic [7:0] bus_rdata;
  ieaf_pkg::ieaf_src_type src_req = '0;
  ieaf_pkg::ieaf_irq_type irq;
  logic [7:0] tmr = 8'h00;
  logic pin_ev = 1'b0;
  logic pin1 = 1'b1;
  logic pin0 = 1'b0;
  int n_mismatch = 0;
  int n_compared = 0;
  int cyc = 0;
  // gating rows: enable written, source levels, expected gated requests
  localparam logic [7:0] EN_T [8] =
    '{8'hCD, 8'h80, 8'h40, 8'h08, 8'h04, 8'h01, 8'hCD, 8'h00};
  localparam logic [4:0] SRC_T [8] =
    '{5'h1F, 5'h1F, 5'h1F, 5'h1F, 5'h1F, 5'h1F, 5'h00, 5'h1F};
  localparam logic [4:0] EXP_T [8] =
    '{5'h1F, 5'h10, 5'h08, 5'h04, 5'h02, 5'h01, 5'h00, 5'h00};

  always #2.5 clk_sys = ~clk_sys;

  ieaf_cpu_model i_cpu (.clk_sys(clk_sys), .bus_req(bus_req),
    .bus_rdata(bus_rdata));
  ieaf_interrupt_flags i_dut (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .bus_req(bus_req), .bus_rdata(bus_rdata), .src_req(src_req),
    .interval_timer_count(tmr), .event_counter_interrupt_pin(pin_ev),
    .external_interrupt_pin1(pin1), .external_interrupt_pin0(pin0),
    .irq(irq));

  task automatic end_of_test();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // irq is sampled 1 ns after the edge, then the caller is realigned to an edge
  task automatic chk_irq(input logic [8:0] exp);
    #1;
    n_compared++;
    if (irq !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t irq %h want %h", $time, irq, exp);
    end
    @(posedge clk_sys);
  endtask

  task automatic chk_reg(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] got;
    i_cpu.rd(a, got);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t reg %h read %h want %h", $time, a, got, exp);
    end
  endtask

  // hang guard, far above the 125 or so cycles the run needs
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_mismatch++;
      end_of_test();
    end
  end

  initial begin
    repeat (4) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    chk_irq(9'h000);
    chk_reg(8'h00, 8'h00);
    chk_reg(8'h01, 8'h20);
    chk_reg(8'h07, 8'h00);
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      i_cpu.wr(8'h00, EN_T[i]);
      src_req <= SRC_T[i];
      repeat (2) @(posedge clk_sys);
      chk_irq({EXP_T[i], 4'h0});
      chk_reg(8'h00, EN_T[i]);
    end
    src_req <= '0;
    $display("test gating done");
    // event pin rising, pin1 falling, pin0 rising, all as interrupts
    i_cpu.wr(8'h03, 8'h75);
    i_cpu.wr(8'h02, 8'h87);
    pin0 <= 1'b1;
    pin1 <= 1'b0;
    pin_ev <= 1'b1;
    tmr <= 8'hFF;
    @(posedge clk_sys);
    tmr <= 8'h00;
    repeat (4) @(posedge clk_sys);
    chk_irq(9'h00F);
    chk_reg(8'h01, 8'hA7);
    i_cpu.wr(8'h02, 8'h00);
    chk_irq(9'h000);
    i_cpu.wr(8'h02, 8'h87);
    i_cpu.wr(8'h01, 8'hA7);
    repeat (8) @(posedge clk_sys);
    chk_reg(8'h01, 8'hA7);
    i_cpu.wr(8'h01, 8'hA6);
    chk_reg(8'h01, 8'hA6);
    i_cpu.wr(8'h01, 8'h00);
    chk_reg(8'h01, 8'h20);
    i_cpu.wr(8'h01, 8'hA7);
    chk_reg(8'h01, 8'h20);
    $display("test flag set and clear done");
    // opposite edges and a count step that is not a wrap
    pin0 <= 1'b0;
    pin1 <= 1'b1;
    pin_ev <= 1'b0;
    tmr <= 8'h01;
    repeat (4) @(posedge clk_sys);
    chk_irq(9'h000);
    chk_reg(8'h01, 8'h20);
    $display("test wrong edges done");
    i_cpu.wr(8'h00, 8'hCD);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    chk_reg(8'h00, 8'h00);
    chk_reg(8'h01, 8'h20);
    $display("test second reset done");
    end_of_test();
  end
endmodule

bind ieaf_interrupt_flags ieaf_checker i_chk (.clk_sys(clk_sys),
  .sys_rst(sys_rst), .bus_req(bus_req), .bus_rdata(bus_rdata),
  .src_req(src_req), .irq(irq));
